// ### hdl/sdp_regs.svh
// constants of the single-pin debug port
`ifndef SDP_REGS_SVH
`define SDP_REGS_SVH
`define SDP_ADDR_STATUS    8'h00
`define SDP_ADDR_CTRL      8'h01
`define SDP_ADDR_TXDATA    8'h02
`define SDP_ADDR_RXDATA    8'h03
`define SDP_ADDR_LINK      8'h04
`define SDP_ADDR_BAUD      8'h05
`define SDP_STAT_DEBUG_BIT 7
`define SDP_STAT_HALT_BIT  6
`define SDP_STAT_HONOR_BIT 5
`define SDP_STATUS_RST     8'h00
`define SDP_CTRL_RST       8'h00
`define SDP_BAUD_RST       16'h0015
`define SDP_FIFO_DEPTH     16
`define SDP_DATA_W         8
`endif

// ### hdl/sdp_pkg.sv
// types of the single-pin debug port
`default_nettype none
package sdp_pkg;
  typedef enum logic [1:0] {SDP_IDLE, SDP_START, SDP_DATA, SDP_STOP} sdp_bit_e;
  typedef logic [7:0] sdp_byte_t;
endpackage : sdp_pkg
`default_nettype wire

// ### hdl/sdp_fifo.sv
// parameterised valid/ready fifo
`timescale 1ns/1ps
`default_nettype none
module sdp_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         ref_clk_i, // clock
  input  wire logic         rst_i,     // async reset
  input  wire logic [W-1:0] in_data_i, // write data
  input  wire logic         in_valid_i,// write request
  output logic              in_ready_o,// not full
  output logic [W-1:0]      out_data_o,// head word
  output logic              out_valid_o,// not empty
  input  wire logic         out_ready_i // pop
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wr_q;
  logic [AW:0]  rd_q;
  logic         push;
  logic         pop;

  assign in_ready_o  = (wr_q - rd_q) != (AW+1)'(D);
  assign out_valid_o = wr_q != rd_q;
  assign out_data_o  = mem[rd_q[AW-1:0]];
  assign push = in_valid_i & in_ready_o;
  assign pop  = out_ready_i & out_valid_o;

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop)  rd_q <= rd_q + 1'b1;
    end
  end

  a_fifo_no_over: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (wr_q - rd_q) <= (AW+1)'(D))
    else $error("fifo holds more words than its depth");
endmodule : sdp_fifo
`default_nettype wire

// ### hdl/sdp_sync.sv
// two-flop synchroniser, idles high
`timescale 1ns/1ps
`default_nettype none
module sdp_sync (
  input  wire logic ref_clk_i, // clock
  input  wire logic rst_i,     // async reset
  input  wire logic d_i,       // async level
  output logic      q_o        // synchronised level
);
  logic meta_q;
  logic sync_q;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end
  assign q_o = sync_q;
endmodule : sdp_sync
`default_nettype wire

// ### hdl/sdp_port.sv
// single-pin open-drain debug serial port with status register
// How it works
// RULE_01: one serial pin carries all debugger traffic
// RULE_02: pin only pulled low or released
// RULE_03: never transmit while receiving, half duplex
// RULE_04: characters framed as standard async serial
// RULE_05: status bit7 debug mode, bit6 halted
// RULE_06: status bit5 shows read-protect honoured or not
// RULE_07: bits 4..0 zero, read-only, reset zero
// RULE_08: honoured protect blocks code access, limits control
// RULE_09: start low, eight data lsb first, stop high
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "sdp_regs.svh"
module sdp_port import sdp_pkg::*; (
  input  wire logic       ref_clk_i,      // 40 MHz clock
  input  wire logic       rst_i,          // async reset, high
  input  wire logic [7:0] addr_i,         // register address
  input  wire logic [7:0] wdata_i,        // write data
  input  wire logic       wr_i,           // write strobe
  input  wire logic       rd_i,           // read strobe
  output logic      [7:0] rdata_o,        // read data, next cycle
  input  wire logic       debug_mode_i,   // core in debug mode
  input  wire logic       halted_i,       // core halted
  input  wire logic       flash_read_protect_option_i, // option bit
  input  wire logic       read_protect_honor_select_i, // 1: no effect
  output logic            code_access_ok_o,  // code reads allowed
  output logic            full_control_ok_o, // all commands allowed
  input  wire logic       debug_serial_pin_i,    // pin level
  output logic            debug_serial_pin_o,    // always 0
  output logic            debug_serial_pin_oe_o, // low = pull low
  output logic            rx_valid_o,     // rx fifo not empty
  output logic            tx_ready_o      // tx fifo not full
);
  logic [15:0] baud_q;
  logic        status_debug_q;
  logic        status_halt_q;
  logic        status_honor_q;
  logic        rx_overrun_q;
  logic        pin_s;

  // status flops sample the core one cycle late
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_debug_q <= 1'b0; // RULE_07
      status_halt_q  <= 1'b0;
      status_honor_q <= 1'b0;
    end else begin
      status_debug_q <= debug_mode_i;    // RULE_05
      status_halt_q  <= halted_i;        // RULE_05
      status_honor_q <= read_protect_honor_select_i; // RULE_06
    end
  end

  // protect effective only when honoured and option programmed low
  always_comb begin
    code_access_ok_o = status_honor_q | flash_read_protect_option_i; // RULE_08
    full_control_ok_o = code_access_ok_o; // RULE_08
  end

  // pin input
  sdp_sync u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .d_i       (debug_serial_pin_i), // RULE_01
    .q_o       (pin_s)
  );

  // fifos
  logic [7:0] txf_data;
  logic       txf_valid;
  logic       txf_pop;
  logic       tx_push;
  logic [7:0] rx_byte_q;
  logic       rx_push_q;
  logic       rxf_ready;
  logic [7:0] rxf_data;
  logic       rxf_pop;

  assign tx_push = wr_i & (addr_i == `SDP_ADDR_TXDATA);
  assign rxf_pop = rd_i & (addr_i == `SDP_ADDR_RXDATA) & rx_valid_o;

  sdp_fifo #(.W(`SDP_DATA_W), .D(`SDP_FIFO_DEPTH)) u_txf (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .in_data_i   (wdata_i),
    .in_valid_i  (tx_push),
    .in_ready_o  (tx_ready_o),
    .out_data_o  (txf_data),
    .out_valid_o (txf_valid),
    .out_ready_i (txf_pop)
  );

  sdp_fifo #(.W(`SDP_DATA_W), .D(`SDP_FIFO_DEPTH)) u_rxf (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .in_data_i   (rx_byte_q),
    .in_valid_i  (rx_push_q),
    .in_ready_o  (rxf_ready),
    .out_data_o  (rxf_data),
    .out_valid_o (rx_valid_o),
    .out_ready_i (rxf_pop)
  );

  // receiver
  sdp_bit_e    rx_st_q;
  logic [15:0] rx_cnt_q;
  logic [2:0]  rx_bit_q;
  logic [7:0]  rx_sh_q;
  sdp_bit_e    tx_st_q;
  logic        rx_busy;
  logic        tx_busy;

  assign rx_busy = rx_st_q != SDP_IDLE;
  assign tx_busy = tx_st_q != SDP_IDLE;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_st_q   <= SDP_IDLE;
      rx_cnt_q  <= '0;
      rx_bit_q  <= '0;
      rx_sh_q   <= '0;
      rx_byte_q <= '0;
      rx_push_q <= 1'b0;
    end else begin
      rx_push_q <= 1'b0;
      unique case (rx_st_q)
        SDP_IDLE: begin
          // own transmission echoes on the line; ignore it
          if (!pin_s && !tx_busy) begin // RULE_03
            rx_st_q  <= SDP_START;
            rx_cnt_q <= {1'b0, baud_q[15:1]};
          end
        end
        SDP_START: begin
          if (rx_cnt_q != 16'h0000) begin
            rx_cnt_q <= rx_cnt_q - 16'h0001;
          end else if (pin_s) begin
            rx_st_q <= SDP_IDLE; // glitch, not a start bit
          end else begin
            rx_st_q  <= SDP_DATA; // RULE_09
            rx_cnt_q <= baud_q;
            rx_bit_q <= '0;
          end
        end
        SDP_DATA: begin
          if (rx_cnt_q != 16'h0000) begin
            rx_cnt_q <= rx_cnt_q - 16'h0001;
          end else begin
            rx_sh_q  <= {pin_s, rx_sh_q[7:1]}; // RULE_09
            rx_cnt_q <= baud_q;
            rx_bit_q <= rx_bit_q + 3'd1;
            if (rx_bit_q == 3'd7) rx_st_q <= SDP_STOP;
          end
        end
        SDP_STOP: begin
          if (rx_cnt_q != 16'h0000) begin
            rx_cnt_q <= rx_cnt_q - 16'h0001;
          end else begin
            rx_st_q <= SDP_IDLE;
            // framing error drops the character
            if (pin_s) begin // RULE_04
              rx_byte_q <= rx_sh_q;
              rx_push_q <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // transmitter
  logic [15:0] tx_cnt_q;
  logic [2:0]  tx_bit_q;
  logic [7:0]  tx_sh_q;
  logic        tx_line_q;

  // a low line means the host has begun; both starting at once would clash
  assign txf_pop = (tx_st_q == SDP_IDLE) & txf_valid & !rx_busy &
                   pin_s; // RULE_03

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_st_q   <= SDP_IDLE;
      tx_cnt_q  <= '0;
      tx_bit_q  <= '0;
      tx_sh_q   <= '0;
      tx_line_q <= 1'b1;
    end else begin
      unique case (tx_st_q)
        SDP_IDLE: begin
          tx_line_q <= 1'b1;
          if (txf_pop) begin
            tx_st_q   <= SDP_START;
            tx_sh_q   <= txf_data;
            tx_cnt_q  <= baud_q;
            tx_line_q <= 1'b0; // RULE_09
          end
        end
        SDP_START: begin
          if (tx_cnt_q != 16'h0000) begin
            tx_cnt_q <= tx_cnt_q - 16'h0001;
          end else begin
            tx_st_q   <= SDP_DATA;
            tx_line_q <= tx_sh_q[0]; // RULE_09
            tx_sh_q   <= {1'b0, tx_sh_q[7:1]};
            tx_bit_q  <= '0;
            tx_cnt_q  <= baud_q;
          end
        end
        SDP_DATA: begin
          if (tx_cnt_q != 16'h0000) begin
            tx_cnt_q <= tx_cnt_q - 16'h0001;
          end else begin
            tx_cnt_q <= baud_q;
            tx_bit_q <= tx_bit_q + 3'd1;
            if (tx_bit_q == 3'd7) begin
              tx_st_q   <= SDP_STOP;
              tx_line_q <= 1'b1; // RULE_04
            end else begin
              tx_line_q <= tx_sh_q[0];
              tx_sh_q   <= {1'b0, tx_sh_q[7:1]};
            end
          end
        end
        SDP_STOP: begin
          if (tx_cnt_q != 16'h0000) begin
            tx_cnt_q <= tx_cnt_q - 16'h0001;
          end else begin
            tx_st_q <= SDP_IDLE;
          end
        end
      endcase
    end
  end

  // open drain: data pin fixed low, enable low pulls the line
  assign debug_serial_pin_o    = 1'b0; // RULE_02
  assign debug_serial_pin_oe_o = tx_line_q; // RULE_02

  // registers
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      baud_q <= `SDP_BAUD_RST;
    end else if (wr_i && addr_i == `SDP_ADDR_BAUD) begin
      baud_q <= {8'h00, wdata_i};
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_overrun_q <= 1'b0;
    end else if (rx_push_q && !rxf_ready) begin
      rx_overrun_q <= 1'b1; // set wins over clear
    end else if (wr_i && addr_i == `SDP_ADDR_LINK && wdata_i[0]) begin
      rx_overrun_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      unique case (addr_i)
        `SDP_ADDR_STATUS: rdata_o <= {status_debug_q, status_halt_q,
                                      status_honor_q, 5'h00}; // RULE_07
        `SDP_ADDR_RXDATA: rdata_o <= rxf_data;
        `SDP_ADDR_LINK:   rdata_o <= {3'h0, rx_overrun_q, rx_busy, tx_busy,
                                      rx_valid_o, tx_ready_o};
        `SDP_ADDR_BAUD:   rdata_o <= baud_q[7:0];
        default:          rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  a_half_duplex: assert property ( // RULE_03
    @(posedge ref_clk_i) disable iff (rst_i)
    !(tx_busy && rx_busy))
    else $error("transmit and receive active together");
  a_line_idle_hi: assert property ( // RULE_09
    @(posedge ref_clk_i) disable iff (rst_i)
    (tx_st_q == SDP_STOP) |-> debug_serial_pin_oe_o)
    else $error("stop bit not released high");
  a_start_low: assert property ( // RULE_09
    @(posedge ref_clk_i) disable iff (rst_i)
    txf_pop |=> !debug_serial_pin_oe_o [*2])
    else $error("start bit not driven low");
  a_pin_od: assert property ( // RULE_02
    @(posedge ref_clk_i) disable iff (rst_i)
    !debug_serial_pin_oe_o |-> (tx_busy && !debug_serial_pin_o))
    else $error("debug pin pulled outside a transmission");
  a_status_read: assert property ( // RULE_07
    @(posedge ref_clk_i) disable iff (rst_i)
    (rd_i && addr_i == `SDP_ADDR_STATUS) |=>
      (rdata_o[4:0] == 5'h00 &&
       rdata_o[7] == $past(status_debug_q)))
    else $error("status read wrong");
  a_status_track: assert property ( // RULE_05
    @(posedge ref_clk_i) disable iff (rst_i)
    ##1 (status_halt_q == $past(halted_i)))
    else $error("halt bit does not follow core");
  a_honor_bit: assert property ( // RULE_06
    @(posedge ref_clk_i) disable iff (rst_i)
    ##1 (status_honor_q == $past(read_protect_honor_select_i)))
    else $error("honour bit wrong");
  a_protect_block: assert property ( // RULE_08
    @(posedge ref_clk_i) disable iff (rst_i)
    (!status_honor_q && !flash_read_protect_option_i) |->
      (!code_access_ok_o && !full_control_ok_o))
    else $error("protected code accessible");
  a_rx_frame: assert property ( // RULE_04
    @(posedge ref_clk_i) disable iff (rst_i)
    rx_push_q |-> $past(pin_s))
    else $error("character accepted without stop bit");
  a_one_pin: assert property ( // RULE_01
    @(posedge ref_clk_i) disable iff (rst_i)
    (rx_st_q == SDP_IDLE && $past(rx_st_q) == SDP_IDLE && !tx_busy &&
     !pin_s) |=> (rx_st_q == SDP_START))
    else $error("start edge on pin missed");
endmodule : sdp_port
`default_nettype wire

// ### verif/sdp_host.sv
// debug host model on the open-drain serial line
`timescale 1ns/1ps
`default_nettype none
module sdp_host #(
  parameter int BIT = 22
) (
  input  wire logic clk_i,     // bench clock
  input  wire logic line_i,    // resolved line level
  input  wire logic dev_low_i, // device pulls low
  output logic      low_o      // 1 pulls the line low
);
  logic [7:0] rx_q[$];
  int         busy  = 0;
  int         clash = 0;

  initial begin
    low_o = 1'b0;
  end

  // stop bit excluded: device may start once our data is out
  always @(posedge clk_i) begin
    if (busy != 0 && dev_low_i) begin
      clash++;
    end
  end

  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    busy = 1;
    for (int i = 0; i < 10; i++) begin
      if (i == 9) begin
        busy = 0;
      end
      low_o <= ~f[i];
      repeat (BIT) @(posedge clk_i);
    end
  endtask : send

  initial begin
    logic [7:0] b;
    forever begin
      @(negedge line_i);
      if (busy == 0 && !low_o) begin
        repeat (BIT / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT) @(posedge clk_i);
          b[i] = line_i;
        end
        repeat (BIT) @(posedge clk_i);
        if (line_i) begin
          rx_q.push_back(b);
        end
      end
    end
  end
endmodule : sdp_host
`default_nettype wire

// ### verif/sdp_port_tb.sv
// self-checking testbench of the single-pin debug port
`timescale 1ns/1ps
`default_nettype none
`include "sdp_regs.svh"
module sdp_port_tb;
  logic       ref_clk_i, rst_i, wr_i, rd_i, dmode, halt, opt, hon;
  logic [7:0] addr_i, wdata_i, rdata_o, v;
  logic       code_ok, ctl_ok, pin_o, oe, rx_valid, tx_ready;
  logic       host_low, line;
  int         miscompares = 0;
  int         n_compared  = 0;
  int         cycles      = 0;

  // pull-up: released line reads high
  assign line = (oe ? 1'b1 : pin_o) & ~host_low;

  sdp_port sdp_port_inst (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .debug_mode_i(dmode), .halted_i(halt),
    .flash_read_protect_option_i(opt),
    .read_protect_honor_select_i(hon),
    .code_access_ok_o(code_ok), .full_control_ok_o(ctl_ok),
    .debug_serial_pin_i(line), .debug_serial_pin_o(pin_o),
    .debug_serial_pin_oe_o(oe), .rx_valid_o(rx_valid),
    .tx_ready_o(tx_ready));

  sdp_host #(.BIT(22)) sdp_host_inst (
    .clk_i(ref_clk_i), .line_i(line), .dev_low_i(~oe), .low_o(host_low));

  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end

  task automatic close_out();
    $display("compared %0d, wrong %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s %h not %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    wr_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    rd_i   <= 1'b0;
    #1 v = rdata_o;
  endtask : rd

  // bounded wait for the host to collect n characters
  task automatic wait_host(input int n);
    for (int i = 0; i < 6000 && sdp_host_inst.rx_q.size() < n; i++) begin
      @(posedge ref_clk_i);
    end
  endtask : wait_host

  task automatic t_reset();
    rd(`SDP_ADDR_STATUS);
    check(v, `SDP_STATUS_RST, "status reset");
    check({6'h00, rx_valid, tx_ready}, 8'h01, "fifo flags");
    check({7'h00, oe}, 8'h01, "line released");
    $display("test reset done");
  endtask : t_reset

  task automatic t_status();
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk_i);
      dmode <= i[2];
      halt <= i[1];
      hon  <= i[0];
      wr(`SDP_ADDR_STATUS, 8'hff);
      rd(`SDP_ADDR_STATUS);
      check(v, {i[2:0], 5'h00}, "status bits");
    end
    rd(8'h07);
    check(v, 8'h00, "unmapped read");
    $display("test status done");
  endtask : t_status

  task automatic t_protect();
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk_i);
      opt <= i[1];
      hon <= i[0];
      // the honour input reaches the outputs through its status flop
      @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      check({6'h00, code_ok, ctl_ok},
            {6'h00, {2{i[1] | i[0]}}}, "protect");
    end
    $display("test protect done");
  endtask : t_protect

  task automatic t_tx();
    wr(`SDP_ADDR_TXDATA, 8'ha5);
    wait_host(1);
    check(sdp_host_inst.rx_q.pop_front(), 8'ha5, "tx char");
    check({7'h00, pin_o}, 8'h00, "pin low only");
    $display("test tx done");
  endtask : t_tx

  task automatic t_rx();
    sdp_host_inst.send(8'h3c);
    for (int i = 0; i < 100 && !rx_valid; i++) @(posedge ref_clk_i);
    rd(`SDP_ADDR_RXDATA);
    check(v, 8'h3c, "rx char");
    check({7'h00, rx_valid}, 8'h00, "rx drained");
    $display("test rx done");
  endtask : t_rx

  // one word leaves at once, sixteen fill the fifo, the last is dropped
  task automatic t_full();
    for (int i = 0; i < 18; i++) begin
      wr(`SDP_ADDR_TXDATA, i[7:0]);
    end
    #1 check({7'h00, tx_ready}, 8'h00, "fifo full");
    wait_host(17);
    repeat (300) @(posedge ref_clk_i);
    check(8'(sdp_host_inst.rx_q.size()), 8'd17, "tx count");
    check(sdp_host_inst.rx_q[16], 8'h10, "tx last");
    sdp_host_inst.rx_q.delete();
    $display("test full done");
  endtask : t_full

  task automatic t_duplex();
    fork
      sdp_host_inst.send(8'h5a);
      begin
        repeat (30) @(posedge ref_clk_i);
        wr(`SDP_ADDR_TXDATA, 8'hc3);
      end
    join
    wait_host(1);
    check(8'(sdp_host_inst.clash), 8'd0, "collision");
    check(sdp_host_inst.rx_q.pop_front(), 8'hc3, "tx after rx");
    rd(`SDP_ADDR_RXDATA);
    check(v, 8'h5a, "rx under tx");
    $display("test duplex done");
  endtask : t_duplex

  // baud register reads back, link status shows an idle port
  task automatic t_regs();
    rd(`SDP_ADDR_BAUD);
    check(v, 8'(`SDP_BAUD_RST), "baud reset");
    wr(`SDP_ADDR_BAUD, 8'h2a);
    rd(`SDP_ADDR_BAUD);
    check(v, 8'h2a, "baud write");
    wr(`SDP_ADDR_BAUD, 8'(`SDP_BAUD_RST));
    rd(`SDP_ADDR_BAUD);
    check(v, 8'(`SDP_BAUD_RST), "baud restored");
    rd(`SDP_ADDR_LINK);
    check(v, 8'h01, "link idle");
    $display("test regs done");
  endtask : t_regs

  // seventeen characters into a sixteen-word fifo: the last is lost
  task automatic t_overrun();
    for (int i = 0; i < 17; i++) begin
      sdp_host_inst.send(i[7:0]);
    end
    repeat (4) @(posedge ref_clk_i);
    rd(`SDP_ADDR_LINK);
    check(v, 8'h13, "overrun set");
    wr(`SDP_ADDR_LINK, 8'h01);
    rd(`SDP_ADDR_LINK);
    check(v, 8'h03, "overrun cleared");
    for (int i = 0; i < 16; i++) begin
      rd(`SDP_ADDR_RXDATA);
      check(v, i[7:0], "rx order");
    end
    check({7'h00, rx_valid}, 8'h00, "rx fifo drained");
    $display("test overrun done");
  endtask : t_overrun

  initial begin
    rst_i   = 1'b1;
    addr_i  = 8'h00;
    wdata_i = 8'h00;
    wr_i    = 1'b0;
    rd_i    = 1'b0;
    dmode   = 1'b0;
    halt    = 1'b0;
    opt     = 1'b0;
    hon     = 1'b0;
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_regs();
    t_status();
    t_protect();
    t_tx();
    t_rx();
    t_full();
    t_duplex();
    t_overrun();
    close_out();
  end
endmodule : sdp_port_tb
`default_nettype wire
